// *** bpcs_cfg.svh ***
// timing and layout constants of the byte parallel config sequencer
`ifndef BPCS_CFG_SVH
`define BPCS_CFG_SVH

`define BPCS_CLK_NS 40
`define BPCS_DATA_W 8
`define BPCS_USER_BIT_LO 1
`define BPCS_STATUS_MIN_NS 10000
`define BPCS_STATUS_MAX_NS 500000
`define BPCS_REQ_TO_LOW_MAX_NS 800
`define BPCS_INIT_MIN_NS 55000
`define BPCS_INIT_MAX_NS 150000
`define BPCS_LOAD_CLK_MAX_PERIOD_NS 8
`define BPCS_CU_PERIODS 4
`define BPCS_USER_INIT_PERIODS 8532
`define BPCS_INIT_FALL_EDGES 2
`define BPCS_FIFO_DEPTH 16
`define BPCS_POR_CYCLES 2500
`define BPCS_LOAD_BYTES 1024

// least times round up to whole cycles
`define BPCS_STATUS_MIN_CYC \
    ((`BPCS_STATUS_MIN_NS + `BPCS_CLK_NS - 1) / `BPCS_CLK_NS)
`define BPCS_INIT_MIN_CYC \
    ((`BPCS_INIT_MIN_NS + `BPCS_CLK_NS - 1) / `BPCS_CLK_NS)
`define BPCS_CU_NS (`BPCS_CU_PERIODS * `BPCS_LOAD_CLK_MAX_PERIOD_NS)
`define BPCS_CU_CYC ((`BPCS_CU_NS + `BPCS_CLK_NS - 1) / `BPCS_CLK_NS)

`endif

// *** bpcs_fifo.sv ***
// small fifo with registered read data
`timescale 1ns/1ps
module bpcs_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic flush,
    // fill side
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // drain side
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
        $error("fifo depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    logic [WIDTH-1:0] out_q;
    logic out_v_q;

    wire logic push = in_valid && in_ready;
    wire logic load_out = (cnt_q != '0) && (!out_v_q || out_ready);
    wire logic [AW:0] cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(load_out);

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_data = out_q;
    assign out_valid = out_v_q;

    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[wp_q] <= in_data;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            out_v_q <= 1'b0;
            out_q <= '0;
        end else if (flush) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            out_v_q <= 1'b0;
        end else begin
            wp_q <= wp_q + AW'(push);
            rp_q <= rp_q + AW'(load_out);
            cnt_q <= cnt_d;
            if (load_out) begin
                out_q <= mem_q[rp_q];
                out_v_q <= 1'b1;
            end else if (out_ready) begin
                out_v_q <= 1'b0;
            end
        end
    end
endmodule // bpcs_fifo

// *** bpcs_host.sv ***
// behavioural configuration host
`timescale 1ns/1ps
module bpcs_host (
    // host pins
    output logic config_request_n,
    output logic load_clock,
    output logic [7:0] load_data
);
    initial begin
        config_request_n = 1'b1;
        load_clock = 1'b0;
        load_data = 8'h00;
    end
    task automatic restart();
        config_request_n = 1'b0;
        #3000;
        config_request_n = 1'b1;
        #500000;
    endtask
    task automatic send(input int n);
        #2007;
        for (int i = 0; i < n; i++) begin
            load_data = 8'(i * 37 + 60);
            #160 load_clock = 1'b1;
            #160 load_clock = 1'b0;
        end
        load_data = ~load_data;
        repeat (2) begin
            #160 load_clock = 1'b1;
            #160 load_clock = 1'b0;
        end
    endtask
endmodule // bpcs_host

// *** bpcs_loader.sv ***
// byte parallel passive configuration load sequencer
`timescale 1ns/1ps
`include "bpcs_cfg.svh"

////////////////////////////////////////////////////////////////////////////
// Operation
// - request low starts fresh reconfiguration
// - completion low within 800 ns
// - status low within 800 ns
// - status low 10 us to 500 us
// - status released within 500 us
// - status low through power-on delay
// - completion low until all data taken
// - internal init 55 to 150 us
// - user clock enabled four periods later
// - user init lasts 8532 user clocks
// - data bits 7..1 become user pins
// - one byte per rising clock edge
module bpcs_loader
    import bpcs_pkg::*;
#(
    parameter int POR_CYCLES = `BPCS_POR_CYCLES,
    parameter int LOAD_BYTES = `BPCS_LOAD_BYTES,
    parameter int FIFO_DEPTH = `BPCS_FIFO_DEPTH
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // host pins
    input wire logic config_request_n,
    input wire logic load_clock,
    input wire logic [7:0] load_data,
    input wire logic user_init_clock,
    input wire logic user_clock_option,
    // open drain status and completion
    input wire logic load_status_n_in,
    output logic load_status_n_out,
    output logic load_status_n_oe,
    input wire logic load_complete_in,
    output logic load_complete_out,
    output logic load_complete_oe,
    // configuration byte stream to the core
    output bpcs_byte_t cfg_byte,
    output logic cfg_valid,
    input wire logic cfg_ready,
    input wire logic cfg_error,
    // mode
    output logic user_mode,
    output logic [6:0] user_pin_en
);
    localparam int NS = 13;
    localparam int CW = 16;
    localparam int BW = 32;

    if (POR_CYCLES < 1 || POR_CYCLES >= (1 << CW)) begin : g_bad_por
        $error("POR_CYCLES out of range");
    end
    if (LOAD_BYTES < 1) begin : g_bad_bytes
        $error("LOAD_BYTES must be positive");
    end

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers

    wire logic [NS-1:0] raw_in = {config_request_n, load_clock,
        user_init_clock, user_clock_option, load_status_n_in,
        load_data};
    // idle levels: request and status high, rest low
    localparam logic [NS-1:0] SYNC_IDLE = 13'h1100;
    logic [NS-1:0] s1_q;
    logic [NS-1:0] s2_q;

    genvar gi;
    generate
        for (gi = 0; gi < NS; gi++) begin : g_sync
            always_ff @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    s1_q[gi] <= SYNC_IDLE[gi];
                    s2_q[gi] <= SYNC_IDLE[gi];
                end else begin
                    s1_q[gi] <= raw_in[gi];
                    s2_q[gi] <= s1_q[gi];
                end
            end
        end
    endgenerate

    wire logic req_n_s = s2_q[12];
    wire logic lclk_s = s2_q[11];
    wire logic uclk_s = s2_q[10];
    wire logic uopt_s = s2_q[9];
    wire logic status_s = s2_q[8];
    wire logic [7:0] data_s = s2_q[7:0];

    logic lclk_p_q;
    logic uclk_p_q;
    wire logic lclk_rise = lclk_s && !lclk_p_q;
    wire logic lclk_fall = !lclk_s && lclk_p_q;
    wire logic uclk_rise = uclk_s && !uclk_p_q;

    ////////////////////////////////////////////////////////////////////////
    // sequencer state

    bpcs_state_t st_q;
    bpcs_state_t st_d;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic [BW-1:0] bytes_q;
    logic [BW-1:0] bytes_d;
    logic status_oe_q;
    logic complete_oe_q;
    logic user_mode_q;
    logic [6:0] pin_en_q;

    wire logic fifo_ready;
    wire logic in_load = (st_q == ST_LOAD);
    wire logic last_byte = (bytes_q == BW'(LOAD_BYTES - 1));
    wire logic take_byte = in_load && lclk_rise && !status_oe_q;
    wire logic overrun = take_byte && !fifo_ready;
    wire logic load_fault = in_load && (cfg_error || overrun);
    wire logic status_min_done = (cnt_q >= CW'(`BPCS_STATUS_MIN_CYC));
    wire logic init_done = (cnt_q >= CW'(`BPCS_INIT_MIN_CYC));
    wire logic cu_done = (cnt_q >= CW'(`BPCS_CU_CYC));
    wire logic uinit_done = (cnt_q >= CW'(`BPCS_USER_INIT_PERIODS));
    wire logic por_done = (cnt_q >= CW'(POR_CYCLES - 1));

    wire bpcs_byte_t fifo_in = '{data: data_s, last: last_byte};

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q + CW'(1);
        bytes_d = bytes_q;
        unique case (st_q)
            // power-on hold
            ST_POR: begin
                if (por_done) begin
                    st_d = ST_STATUS_LOW;
                    cnt_d = '0;
                end
            end
            // status pulse timing
            ST_STATUS_LOW: begin
                bytes_d = '0;
                if (!req_n_s) begin
                    cnt_d = '0;
                end else if (status_min_done) begin
                    st_d = ST_LOAD;
                    cnt_d = '0;
                end
            end
            ST_LOAD: begin
                cnt_d = cnt_q;
                if (take_byte) begin
                    bytes_d = bytes_q + BW'(1);
                    if (last_byte) begin
                        st_d = ST_DONE_WAIT;
                        cnt_d = '0;
                    end
                end
            end
            // count falling load clock edges
            ST_DONE_WAIT: begin
                cnt_d = cnt_q + CW'(lclk_fall);
                if (cnt_q == CW'(`BPCS_INIT_FALL_EDGES)) begin
                    st_d = uopt_s ? ST_CU_WAIT : ST_INIT;
                    cnt_d = '0;
                end
            end
            ST_CU_WAIT: begin
                if (cu_done) begin
                    st_d = ST_INIT;
                    cnt_d = '0;
                end
            end
            ST_INIT: begin
                if (uopt_s) begin
                    cnt_d = cnt_q + CW'(uclk_rise);
                end
                if (uopt_s ? uinit_done : init_done) begin
                    st_d = ST_USER;
                end
            end
            ST_USER: begin
                cnt_d = cnt_q;
            end
            ST_ERROR: begin
                cnt_d = '0;
            end
        endcase
        if (load_fault) begin
            st_d = ST_ERROR;
        end
        if (!req_n_s && st_q != ST_POR) begin
            st_d = ST_STATUS_LOW;
            if (st_q != ST_STATUS_LOW) begin
                cnt_d = '0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_POR;
            cnt_q <= '0;
            bytes_q <= '0;
            lclk_p_q <= 1'b0;
            uclk_p_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            bytes_q <= bytes_d;
            lclk_p_q <= lclk_s;
            uclk_p_q <= uclk_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drivers

    wire logic status_drv = (st_d == ST_POR) || (st_d == ST_STATUS_LOW)
        || (st_d == ST_ERROR);
    wire logic complete_drv = (st_d == ST_POR) || (st_d == ST_STATUS_LOW)
        || (st_d == ST_LOAD) || (st_d == ST_ERROR);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            status_oe_q <= 1'b1;
            complete_oe_q <= 1'b1;
            user_mode_q <= 1'b0;
            pin_en_q <= '0;
        end else begin
            status_oe_q <= status_drv;
            complete_oe_q <= complete_drv;
            user_mode_q <= (st_d == ST_USER);
            pin_en_q <= {7{st_d == ST_USER}};
        end
    end

    assign load_status_n_out = 1'b0;
    assign load_status_n_oe = status_oe_q;
    assign load_complete_out = 1'b0;
    assign load_complete_oe = complete_oe_q;
    assign user_mode = user_mode_q;
    assign user_pin_en = pin_en_q;

    ////////////////////////////////////////////////////////////////////////
    // byte buffer

    bpcs_fifo #(
        .WIDTH($bits(bpcs_byte_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .flush(st_q == ST_STATUS_LOW),
        .in_data(fifo_in),
        .in_valid(take_byte),
        .in_ready(fifo_ready),
        .out_data(cfg_byte),
        .out_valid(cfg_valid),
        .out_ready(cfg_ready)
    );
endmodule // bpcs_loader

// *** bpcs_loader_checker.sv ***
// checker of the loader ports
`timescale 1ns/1ps
module bpcs_loader_checker
    import bpcs_pkg::*;
#(
    parameter int POR_CYCLES = 4
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // pins
    input wire logic config_request_n,
    input wire logic user_init_clock,
    input wire logic user_clock_option,
    input wire logic load_status_n_oe,
    input wire logic load_complete_oe,
    // core side
    input wire logic cfg_error,
    input wire logic user_mode,
    input wire logic [6:0] user_pin_en
);
    logic [15:0] hi_q, rel_q, done_q, uc_q;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hi_q <= 16'h0;
            rel_q <= 16'h0;
            done_q <= 16'h0;
            uc_q <= 16'h0;
        end else begin
            hi_q <= load_status_n_oe ? hi_q + {15'h0, ~&hi_q} : 16'h0;
            rel_q <= config_request_n ? rel_q + {15'h0, ~&rel_q} : 16'h0;
            done_q <= load_complete_oe ? 16'h0 : done_q + {15'h0, ~&done_q};
            uc_q <= load_complete_oe ? 16'h0 :
                uc_q + {15'h0, $rose(user_init_clock) && ~&uc_q};
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    chk_req_done_low: assert property (
        $fell(config_request_n) |-> ##[1:20] load_complete_oe)
        else $error("completion not pulled after request");
    chk_req_stat_low: assert property (
        $fell(config_request_n) |-> ##[1:20] load_status_n_oe)
        else $error("status not pulled after request");
    chk_status_min: assert property (
        $fell(load_status_n_oe) |-> hi_q >= 16'h00FA)
        else $error("status pulse too short");
    chk_status_max: assert property (
        rel_q == 16'h30D4 |-> !load_status_n_oe)
        else $error("status held too long after request");
    chk_por_hold: assert property (
        $rose(rst_n) |-> load_status_n_oe [*4])
        else $error("status released during power-on delay");
    chk_done_held: assert property (
        load_status_n_oe |-> load_complete_oe)
        else $error("completion released while status low");
    chk_user_lines: assert property (
        user_mode |-> !load_status_n_oe && !load_complete_oe)
        else $error("lines pulled in user mode");
    chk_init_int: assert property (
        $rose(user_mode) && !user_clock_option |->
        done_q >= 16'h055F && done_q <= 16'h0EA6)
        else $error("internal init time out of range");
    chk_init_user: assert property (
        $rose(user_mode) && user_clock_option |-> uc_q >= 16'h2154)
        else $error("user clock init too short");
    chk_pin_hand: assert property (
        user_pin_en == {7{user_mode}})
        else $error("user pin enables wrong");
    chk_err_abort: assert property (
        cfg_error && load_complete_oe && !load_status_n_oe |->
        ##[1:3] load_status_n_oe)
        else $error("error did not pull status");
endmodule // bpcs_loader_checker

bind bpcs_loader bpcs_loader_checker #(.POR_CYCLES(POR_CYCLES)) chk_u (
    .clock, .rst_n, .config_request_n, .user_init_clock,
    .user_clock_option, .load_status_n_oe, .load_complete_oe,
    .cfg_error, .user_mode, .user_pin_en);

// *** bpcs_pkg.sv ***
// types of the byte parallel config sequencer
package bpcs_pkg;

    typedef struct packed {
        logic [7:0] data;
        logic last;
    } bpcs_byte_t;

    typedef enum logic [2:0] {
        ST_POR,
        ST_STATUS_LOW,
        ST_LOAD,
        ST_DONE_WAIT,
        ST_CU_WAIT,
        ST_INIT,
        ST_USER,
        ST_ERROR
    } bpcs_state_t;

endpackage

// *** test_byte_parallel_config_sequencer.sv ***
// self-checking bench of the loader
`timescale 1ns/1ps
`include "bpcs_cfg.svh"
module test_byte_parallel_config_sequencer
    import bpcs_pkg::*;
;
    localparam int NB = 20;
    logic clock = 1'b0, rst_n = 1'b0, uclk = 1'b0;
    logic opt = 1'b0, ready = 1'b1, err = 1'b0;
    logic req_n, lclk, st_out, st_oe, cd_out, cd_oe, valid, umode;
    logic [7:0] ldata;
    logic [6:0] pin_en;
    bpcs_byte_t cbyte;
    bpcs_byte_t got_q[$];
    wire st_w = st_oe ? st_out : 1'b1;
    wire cd_w = cd_oe ? cd_out : 1'b1;
    int n_mismatch = 0, checks = 0, k;
    always #20 clock = ~clock;
    always #83 uclk = ~uclk;
    always @(posedge clock) begin
        if (valid === 1'b1 && ready === 1'b1) got_q.push_back(cbyte);
    end
    bpcs_host host_u (.config_request_n(req_n), .load_clock(lclk),
        .load_data(ldata));
    bpcs_loader #(.POR_CYCLES(4), .LOAD_BYTES(NB)) dut_u (
        .clock(clock), .rst_n(rst_n), .config_request_n(req_n),
        .load_clock(lclk), .load_data(ldata), .user_init_clock(uclk),
        .user_clock_option(opt), .load_status_n_in(st_w),
        .load_status_n_out(st_out), .load_status_n_oe(st_oe),
        .load_complete_in(cd_w), .load_complete_out(cd_out),
        .load_complete_oe(cd_oe), .cfg_byte(cbyte), .cfg_valid(valid),
        .cfg_ready(ready), .cfg_error(err), .user_mode(umode),
        .user_pin_en(pin_en));
    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic wait_hi(input int sel, input int lim, output int n);
        n = 0;
        while (!(sel == 0 ? st_w === 1'b1 : umode === 1'b1)) begin
            @(negedge clock);
            n++;
            if (n > lim) begin
                n_mismatch++;
                end_sim();
            end
        end
    endtask
    task automatic chk_bytes();
        chk(got_q.size(), NB);
        foreach (got_q[i]) chk(got_q[i], {8'(i * 37 + 60), i == NB - 1});
        got_q.delete();
    endtask
    task automatic restart();
        fork
            host_u.restart();
            begin
                repeat (20) @(negedge clock);
                chk(st_w, 0);
                chk(cd_w, 0);
                chk(umode, 0);
            end
        join
        chk(st_w, 1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_power_load();
        chk(st_w, 0);
        chk(cd_w, 0);
        wait_hi(0, 400, k);
        ready = 1'b0;
        fork
            host_u.send(NB);
            begin
                repeat (80) @(negedge clock);
                ready = 1'b1;
            end
        join
        chk(cd_w, 1);
        wait_hi(1, 4000, k);
        chk(k > 1350 && k < 3750, 1);
        chk(pin_en, 7'h7F);
        chk_bytes();
        $display("t_power_load done");
    endtask
    task automatic t_overrun();
        restart();
        ready = 1'b0;
        host_u.send(NB);
        chk(st_w, 0);
        chk(cd_w, 0);
        @(negedge clock);
        ready = 1'b1;
        repeat (30) @(negedge clock);
        chk(got_q.size(), `BPCS_FIFO_DEPTH + 1);
        got_q.delete();
        $display("t_overrun done");
    endtask
    task automatic t_core_err();
        restart();
        fork
            host_u.send(NB);
            begin
                repeat (120) @(negedge clock);
                err = 1'b1;
                @(negedge clock);
                err = 1'b0;
                repeat (4) @(negedge clock);
                chk(st_w, 0);
            end
        join
        chk(cd_w, 0);
        chk(umode, 0);
        got_q.delete();
        $display("t_core_err done");
    endtask
    task automatic t_user_clock();
        opt = 1'b1;
        restart();
        host_u.send(NB);
        chk(cd_w, 1);
        chk_bytes();
        wait_hi(1, 40000, k);
        chk(k * 40 + 1000 >= 8532 * 166, 1);
        chk(pin_en, 7'h7F);
        $display("t_user_clock done");
    endtask
    initial begin
        repeat (20) @(negedge clock);
        rst_n = 1'b1;
        repeat (2) @(negedge clock);
        t_power_load();
        t_overrun();
        t_core_err();
        t_user_clock();
        end_sim();
    end
endmodule // test_byte_parallel_config_sequencer
